// *** hdl/rst_cause_pkg.sv ***
// package: register map, field positions and timing constants of the reset-cause block
package rst_cause_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0]  IDX_CORE_STATUS   = 8'h83;
    localparam logic [7:0]  IDX_RESET_CAUSE   = 8'h8E;
    localparam logic [7:0]  IDX_CONFIG        = 8'hA0;
    localparam logic [7:0]  IDX_IRQ_STATUS    = 8'hA1;
    localparam logic [7:0]  IDX_IRQ_ENABLE    = 8'hA2;
    localparam logic [7:0]  IDX_IRQ_CLEAR     = 8'hA3;
    localparam logic [7:0]  IDX_RESET_STATE   = 8'hA4;
    // core status fields
    localparam int          POS_TIMEOUT       = 4;
    localparam int          POS_POWERDOWN     = 3;
    // reset cause fields
    localparam int          POS_BROWNOUT      = 0;
    localparam int          POS_POWERON       = 1;
    // config fields
    localparam int          POS_CFG_BOD_EN    = 0;
    localparam int          POS_CFG_PUD_DIS   = 1;
    localparam int          POS_CFG_OSC_LO    = 2;
    localparam int          POS_CFG_OSC_HI    = 3;
    localparam logic [3:0]  CONFIG_RESET      = 4'h0;
    // event bit positions
    localparam int          EV_POWERON        = 0;
    localparam int          EV_BROWNOUT       = 1;
    localparam int          EV_WATCHDOG       = 2;
    localparam int          EV_PIN            = 3;
    localparam int          EV_RELEASE        = 4;
    localparam int          NUM_EV            = 5;
    // timing
    localparam int          PUT_MS            = 72;
    localparam int          SLOW_CLK_HZ       = 32000;
    localparam int          PUT_TICKS         = (PUT_MS * SLOW_CLK_HZ) / 1000;
    localparam int          OST_CYCLES        = 1024;
    localparam int          CLK_MHZ           = 200;
    localparam int          SLOW_DIV          = (CLK_MHZ * 1000000) / SLOW_CLK_HZ;
    localparam logic [31:0] APB_ERR_DATA      = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        OSC_LOW_POWER,
        OSC_MID_CRYSTAL,
        OSC_HIGH_SPEED,
        OSC_RES_CAP
    } osc_mode_t;

    typedef struct packed
    {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed
    {
        logic        poweron;
        logic        brownout;
        logic        watchdog;
        logic        pin;
        logic        wake;
    } reset_src_t;
endpackage : rst_cause_pkg

// *** hdl/startup_timer.sv ***
// start-up sequencer: power-up interval then oscillator start-up interval
module startup_timer #(
    parameter int PUT_COUNT = rst_cause_pkg::PUT_TICKS,
    parameter int OST_COUNT = rst_cause_pkg::OST_CYCLES,
    parameter int SLOW_DIV  = rst_cause_pkg::SLOW_DIV
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic restart_put,
    input  wire logic restart_ost,
    input  wire logic osc_tick,
    input  wire logic crystal_mode,
    input  wire logic holding,
    output logic      busy
);
    initial
    begin
        if (PUT_COUNT < 1 || OST_COUNT < 1 || SLOW_DIV < 2)
            $error("startup_timer: counts must be positive");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_PUT, ST_OST} st_t;

    st_t         state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] div_q, div_d;
    logic        slow_tick;

    assign slow_tick = (div_q == 32'(SLOW_DIV - 1));

    // ====================================
    // sequencing
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        div_d   = slow_tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
        if (restart_put)
        begin
            // interval restarts from zero on each new request
            state_d = ST_PUT;
            cnt_d   = 32'h0000_0000;
            div_d   = 32'h0000_0000;
        end
        else if (restart_ost)
        begin
            state_d = crystal_mode ? ST_OST : ST_IDLE;
            cnt_d   = 32'h0000_0000;
        end
        else if (!holding)
        begin
            case (state_q)
                ST_PUT:
                begin
                    // slow internal clock paces the power-up interval
                    if (slow_tick)
                        cnt_d = cnt_q + 32'h0000_0001;
                    if (slow_tick && cnt_q == 32'(PUT_COUNT - 1))
                    begin
                        // oscillator interval follows power-up interval in crystal mode
                        state_d = crystal_mode ? ST_OST : ST_IDLE;
                        cnt_d   = 32'h0000_0000;
                    end
                end
                ST_OST:
                begin
                    if (osc_tick)
                        cnt_d = cnt_q + 32'h0000_0001;
                    if (osc_tick && cnt_q == 32'(OST_COUNT - 1))
                        state_d = ST_IDLE;
                end
                default:
                    state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= 32'h0000_0000;
            div_q   <= 32'h0000_0000;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            div_q   <= div_d;
        end
    end

    assign busy = (state_q != ST_IDLE);
endmodule // startup_timer

// *** hdl/reset_cause_and_timeout.sv ***
// reset-cause flags, start-up hold and APB register file
// Contract
// - cause register at 8Eh, bits 0 and 1
// - brown-out flag cleared by brown-out, software sets
// - brown-out flag meaningless when detection disabled
// - power-on flag cleared only by power-on; the code also clears it when software writes 0 to bit 1
// - crystal hold: 72 ms plus 1024 periods
// - power-on sets timeout and powerdown flags
// - pin keeps, watchdog clears timeout flag(s)
// - pin reset in sleep: timeout 1, powerdown 0
// - power-on pattern 0001 1xxx and 0x
// - other resets pattern 000q quuu and uq
// - cause bits 7..2 read zero, ignore writes
// - power-up interval then oscillator interval
// - RC mode, timer disabled: no delay
// - brown-out during timer restarts it
//
// The APB register port was decided locally.
module reset_cause_and_timeout #(
    parameter int PUT_COUNT = rst_cause_pkg::PUT_TICKS,
    parameter int OST_COUNT = rst_cause_pkg::OST_CYCLES,
    parameter int SLOW_DIV  = rst_cause_pkg::SLOW_DIV
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        poweron_event,
    input  wire logic        brownout_event,
    input  wire logic        watchdog_event,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        sleeping,
    input  wire logic        wake_event,
    input  wire logic        osc_tick,
    output logic             core_reset,
    output logic             irq
);
    initial
    begin
        if (PUT_COUNT < 1 || OST_COUNT < 1)
            $error("reset_cause_and_timeout: bad counts");
    end

    // ====================================
    // pin synchronisers
    logic [1:0] pin_sync_q;
    logic [1:0] bo_sync_q;
    logic [1:0] wd_sync_q;
    logic [1:0] wk_sync_q;
    logic [1:0] sl_sync_q;
    logic [1:0] tk_sync_q;
    logic       pin_low_q;
    logic       tick_prev_q;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_sync_q  <= 2'h3;
            bo_sync_q   <= 2'h0;
            wd_sync_q   <= 2'h0;
            wk_sync_q   <= 2'h0;
            sl_sync_q   <= 2'h0;
            tk_sync_q   <= 2'h0;
            pin_low_q   <= 1'b0;
            tick_prev_q <= 1'b0;
        end
        else
        begin
            pin_sync_q  <= {pin_sync_q[0], ext_reset_pin_n};
            bo_sync_q   <= {bo_sync_q[0], brownout_event};
            wd_sync_q   <= {wd_sync_q[0], watchdog_event};
            wk_sync_q   <= {wk_sync_q[0], wake_event};
            sl_sync_q   <= {sl_sync_q[0], sleeping};
            tk_sync_q   <= {tk_sync_q[0], osc_tick};
            pin_low_q   <= !pin_sync_q[1];
            tick_prev_q <= tk_sync_q[1];
        end
    end

    logic pin_fall;
    logic osc_edge;
    logic wd_pulse;
    logic bo_level;
    assign pin_fall = !pin_sync_q[1] && !pin_low_q;
    assign osc_edge = tk_sync_q[1] && !tick_prev_q;
    assign wd_pulse = wd_sync_q[1];
    assign bo_level = bo_sync_q[1];

    // ====================================
    // flag state
    // power-on: arst_n is the power-on reset; first cycle after release is the event
    logic       por_pend_q, por_pend_d;
    logic       timeout_n_q, timeout_n_d;
    logic       powerdown_n_q, powerdown_n_d;
    logic       brownout_flag_n_q, brownout_flag_n_d;
    logic       poweron_flag_n_q, poweron_flag_n_d;
    logic [3:0] config_q, config_d;
    logic [4:0] irq_status_q, irq_status_d;
    logic [4:0] irq_enable_q, irq_enable_d;
    logic       bo_active_q, bo_active_d;
    logic [4:0] events;
    logic       wr_en;
    logic       bod_en;
    logic       timer_busy;
    logic       hold_q, hold_d;

    assign bod_en = config_q[rst_cause_pkg::POS_CFG_BOD_EN];
    assign wr_en  = psel && penable && pwrite;

    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    logic bo_rise;
    assign bo_rise = bo_level && bod_en && !bo_active_q;

    always_comb
    begin
        por_pend_d        = 1'b0;
        timeout_n_d       = timeout_n_q;
        powerdown_n_d     = powerdown_n_q;
        brownout_flag_n_d = brownout_flag_n_q;
        poweron_flag_n_d  = poweron_flag_n_q;
        config_d          = config_q;
        irq_enable_d      = irq_enable_q;
        bo_active_d       = bo_level && bod_en;
        events            = 5'h00;
        // software writes first, hardware events override
        if (wr_en && hit(paddr, rst_cause_pkg::IDX_RESET_CAUSE))
        begin
            // bits 7..2 are not stored
            brownout_flag_n_d = pwdata[rst_cause_pkg::POS_BROWNOUT];
            poweron_flag_n_d  = pwdata[rst_cause_pkg::POS_POWERON];
        end
        if (wr_en && hit(paddr, rst_cause_pkg::IDX_CONFIG))
            config_d = pwdata[3:0];
        if (wr_en && hit(paddr, rst_cause_pkg::IDX_IRQ_ENABLE))
            irq_enable_d = pwdata[4:0];
        if (por_pend_q || poweron_event)
        begin
            // power-on: 0001 1xxx and 0x
            timeout_n_d      = 1'b1;
            powerdown_n_d    = 1'b1;
            poweron_flag_n_d = 1'b0;
            events[rst_cause_pkg::EV_POWERON] = 1'b1;
        end
        else if (bo_rise)
        begin
            // brown-out clears only its flag; meaningless without detection
            brownout_flag_n_d = 1'b0;
            events[rst_cause_pkg::EV_BROWNOUT] = 1'b1;
        end
        else if (wd_pulse)
        begin
            // watchdog: timeout cleared, powerdown cleared on wake from sleep
            timeout_n_d = 1'b0;
            if (sl_sync_q[1])
                powerdown_n_d = 1'b0;
            events[rst_cause_pkg::EV_WATCHDOG] = 1'b1;
        end
        else if (pin_fall)
        begin
            // pin: unchanged when running, 1/0 when asleep
            if (sl_sync_q[1])
            begin
                timeout_n_d   = 1'b1;
                powerdown_n_d = 1'b0;
            end
            events[rst_cause_pkg::EV_PIN] = 1'b1;
        end
        events[rst_cause_pkg::EV_RELEASE] = hold_q && !hold_d;
        // set wins over clear
        irq_status_d = irq_status_q | events;
        if (wr_en && hit(paddr, rst_cause_pkg::IDX_IRQ_CLEAR))
            irq_status_d = (irq_status_q & ~pwdata[4:0]) | events;
    end

    // ====================================
    // start-up hold
    logic       crystal;
    logic       pud_dis;
    logic       restart_put;
    logic       restart_ost;
    assign crystal = config_q[rst_cause_pkg::POS_CFG_OSC_HI:rst_cause_pkg::POS_CFG_OSC_LO]
                     != 2'(rst_cause_pkg::OSC_RES_CAP);
    // brown-out detection forces the power-up interval on
    assign pud_dis = config_q[rst_cause_pkg::POS_CFG_PUD_DIS] && !bod_en;
    // power-up with timer, or brown-out: restart interval
    assign restart_put = ((por_pend_q || poweron_event) && !pud_dis) || (bo_level && bod_en);
    // timer off or wake: crystal interval only, RC gets none
    assign restart_ost = ((por_pend_q || poweron_event) && pud_dis) || wk_sync_q[1];

    startup_timer #(
        .PUT_COUNT (PUT_COUNT),
        .OST_COUNT (OST_COUNT),
        .SLOW_DIV  (SLOW_DIV)
    ) u_timer (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .restart_put  (restart_put),
        .restart_ost  (restart_ost),
        .osc_tick     (osc_edge),
        .crystal_mode (crystal),
        .holding      (bo_level && bod_en),
        .busy         (timer_busy)
    );

    // core held while brown-out, pin low or timer running
    assign hold_d = timer_busy || restart_put || restart_ost || (bo_level && bod_en)
                    || !pin_sync_q[1];

    // ====================================
    // APB read
    logic [31:0] rdata_d;
    logic        err_d;
    always_comb
    begin
        rdata_d = rst_cause_pkg::APB_ERR_DATA;
        err_d   = 1'b0;
        if (hit(paddr, rst_cause_pkg::IDX_CORE_STATUS))
            rdata_d = {27'h0, timeout_n_q, powerdown_n_q, 3'h0};
        else if (hit(paddr, rst_cause_pkg::IDX_RESET_CAUSE))
            rdata_d = {30'h0, poweron_flag_n_q, brownout_flag_n_q};
        else if (hit(paddr, rst_cause_pkg::IDX_CONFIG))
            rdata_d = {28'h0, config_q};
        else if (hit(paddr, rst_cause_pkg::IDX_IRQ_STATUS))
            rdata_d = {27'h0, irq_status_q};
        else if (hit(paddr, rst_cause_pkg::IDX_IRQ_ENABLE))
            rdata_d = {27'h0, irq_enable_q};
        else if (hit(paddr, rst_cause_pkg::IDX_RESET_STATE))
            rdata_d = {31'h0, hold_q};
        else if (!hit(paddr, rst_cause_pkg::IDX_IRQ_CLEAR))
            err_d = 1'b1;
    end

    logic setup;
    assign setup = psel && !penable;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            por_pend_q        <= 1'b1;
            timeout_n_q       <= 1'b1;
            powerdown_n_q     <= 1'b1;
            brownout_flag_n_q <= 1'b0;
            poweron_flag_n_q  <= 1'b0;
            config_q          <= rst_cause_pkg::CONFIG_RESET;
            irq_status_q      <= 5'h00;
            irq_enable_q      <= 5'h00;
            bo_active_q       <= 1'b0;
            hold_q            <= 1'b1;
            prdata            <= 32'h0000_0000;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            core_reset        <= 1'b1;
            irq               <= 1'b0;
        end
        else
        begin
            por_pend_q        <= por_pend_d;
            timeout_n_q       <= timeout_n_d;
            powerdown_n_q     <= powerdown_n_d;
            brownout_flag_n_q <= brownout_flag_n_d;
            poweron_flag_n_q  <= poweron_flag_n_d;
            config_q          <= config_d;
            irq_status_q      <= irq_status_d;
            irq_enable_q      <= irq_enable_d;
            bo_active_q       <= bo_active_d;
            hold_q            <= hold_d;
            // no wait state: data staged in setup, pready in the first access cycle
            pready            <= setup;
            prdata            <= setup && !pwrite ? rdata_d : prdata;
            pslverr           <= setup && err_d;
            core_reset        <= hold_d;
            irq               <= |(irq_status_d & irq_enable_d);
        end
    end

    // ====================================
    // checks
    property p_por_flags;
        @(posedge clk_sys) disable iff (!arst_n)
        poweron_event |=> (timeout_n_q && powerdown_n_q && !poweron_flag_n_q);
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

    property p_cause_upper_zero;
        @(posedge clk_sys) disable iff (!arst_n)
        pready && hit(paddr, rst_cause_pkg::IDX_RESET_CAUSE) && !pwrite |-> prdata[31:2] == 30'h0;
    endproperty
    a_cause_upper_zero: assert property (p_cause_upper_zero) else $error("cause high bits set");

    property p_hold_after_por;
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(por_pend_q == 1'b0) |-> core_reset;
    endproperty
    a_hold_after_por: assert property (p_hold_after_por) else $error("no hold");

    property p_pin_sleep;
        @(posedge clk_sys) disable iff (!arst_n)
        pin_fall && sl_sync_q[1] && !wd_pulse && !bo_rise && !por_pend_q && !poweron_event
        |=> timeout_n_q && !powerdown_n_q;
    endproperty
    a_pin_sleep: assert property (p_pin_sleep) else $error("sleep pin flags");

    property p_wd_clears;
        @(posedge clk_sys) disable iff (!arst_n)
        wd_pulse && !poweron_event && !por_pend_q && !bo_rise |=> !timeout_n_q;
    endproperty
    a_wd_clears: assert property (p_wd_clears) else $error("watchdog kept timeout flag");

    property p_bo_restart;
        @(posedge clk_sys) disable iff (!arst_n)
        bo_level && bod_en |=> core_reset [*2];
    endproperty
    a_bo_restart: assert property (p_bo_restart) else $error("brown-out did not hold");

    c_wd:   cover property (@(posedge clk_sys) disable iff (!arst_n) wd_pulse);
    c_pin:  cover property (@(posedge clk_sys) disable iff (!arst_n) pin_fall && sl_sync_q[1]);
    c_rel:  cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(core_reset));
endmodule // reset_cause_and_timeout

// *** dv/tb.sv ***
// self-checking bench for the reset-cause and start-up hold block
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ==============================================================
    // parameters and signals
    // ==============================================================
    // shortened counts keep the run brief; hold limits derive from them
    localparam int PUT_N = 4;
    localparam int OST_N = 4;
    localparam int DIV_N = 4;
    localparam int OSC_P = 6;
    localparam int HOLD_XTAL = PUT_N * DIV_N + OST_N * OSC_P;
    localparam int HOLD_RC = PUT_N * DIV_N;
    // first oscillator edge may come at any phase of its period
    localparam int HOLD_MIN = HOLD_RC + (OST_N - 1) * OSC_P;
    localparam int SLACK = 30;
    localparam logic [11:0] a_status = {2'h0, rst_cause_pkg::IDX_CORE_STATUS, 2'h0};
    localparam logic [11:0] a_cause  = {2'h0, rst_cause_pkg::IDX_RESET_CAUSE, 2'h0};
    localparam logic [11:0] a_config = {2'h0, rst_cause_pkg::IDX_CONFIG, 2'h0};
    localparam logic [11:0] a_irq_st = {2'h0, rst_cause_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] a_irq_en = {2'h0, rst_cause_pkg::IDX_IRQ_ENABLE, 2'h0};
    localparam logic [11:0] a_irq_cl = {2'h0, rst_cause_pkg::IDX_IRQ_CLEAR, 2'h0};

    logic        clk_sys;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        poweron_event;
    logic        brownout_event;
    logic        watchdog_event;
    logic        ext_reset_pin_n;
    logic        sleeping;
    logic        wake_event;
    logic        osc_tick;
    logic        core_reset;
    logic        irq;
    int          num_errors;
    int          n_tests;
    int          cyc;
    int          hold;

    reset_cause_and_timeout #(
        .PUT_COUNT (PUT_N),
        .OST_COUNT (OST_N),
        .SLOW_DIV  (DIV_N)
    ) dut_u (
        .clk_sys         (clk_sys),
        .arst_n          (arst_n),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .poweron_event   (poweron_event),
        .brownout_event  (brownout_event),
        .watchdog_event  (watchdog_event),
        .ext_reset_pin_n (ext_reset_pin_n),
        .sleeping        (sleeping),
        .wake_event      (wake_event),
        .osc_tick        (osc_tick),
        .core_reset      (core_reset),
        .irq             (irq)
    );

    // ==============================================================
    // clocks and watchdog of the run
    // ==============================================================
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        osc_tick = 1'b0;
        forever
        begin
            repeat (OSC_P / 2) @(posedge clk_sys);
            osc_tick <= ~osc_tick;
        end
    end

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    // ==============================================================
    // shared tasks
    // ==============================================================
    task automatic end_sim();
        $display("errors=%0d comparisons=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until pready is seen at a rising edge, released after it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd & m, e);
    endtask

    // 0 power-on request, 1 brown-out, 2 watchdog, 3 reset pin
    task automatic fire(input int k);
        @(posedge clk_sys);
        case (k)
            0: poweron_event <= 1'b1;
            1: brownout_event <= 1'b1;
            2: watchdog_event <= 1'b1;
            default: ext_reset_pin_n <= 1'b0;
        endcase
        repeat (k == 0 ? 1 : 4) @(posedge clk_sys);
        poweron_event   <= 1'b0;
        brownout_event  <= 1'b0;
        watchdog_event  <= 1'b0;
        ext_reset_pin_n <= 1'b1;
    endtask

    // cycles that the core is held, zero if it is never held
    task automatic wait_hold(output int n);
        int w;
        w = 0;
        n = 0;
        while (core_reset !== 1'b1 && w < 10)
        begin
            @(posedge clk_sys);
            w = w + 1;
        end
        while (core_reset === 1'b1 && n < 2000)
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
    endtask

    // ==============================================================
    // scenarios
    // ==============================================================
    task automatic t_poweron();
        wait_hold(hold);
        chk({31'h0, hold >= HOLD_MIN && hold <= HOLD_XTAL + SLACK}, 32'h1);
        rdchk(a_status, 32'hFF, 32'h18);
        rdchk(a_cause, 32'hFE, 32'h00);
    endtask

    task automatic t_cause_bits();
        logic [31:0] rd;
        logic        err;
        wr(a_cause, 32'hFF);
        rdchk(a_cause, 32'hFFFF_FFFF, 32'h03);
        apb(1'b0, 12'h3FC, 32'h0000_0000, rd, err);
        chk({rd[30:0], err}, 32'h1);
    endtask

    task automatic t_pin_irq();
        wr(a_irq_cl, 32'h1F);
        wr(a_irq_en, 32'h08);
        fire(3);
        wait_hold(hold);
        rdchk(a_status, 32'h18, 32'h18);
        rdchk(a_cause, 32'hFF, 32'h03);
        rdchk(a_irq_st, 32'h08, 32'h08);
        chk({31'h0, irq}, 32'h1);
        wr(a_irq_en, 32'h00);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(a_irq_en, 32'h08);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        wr(a_irq_cl, 32'h1F);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(a_irq_en, 32'h00);
    endtask

    task automatic t_watchdog_and_sleep();
        fire(2);
        wait_hold(hold);
        rdchk(a_status, 32'h18, 32'h08);
        wr(a_config, 32'h0E);
        fire(0);
        wait_hold(hold);
        chk({31'h0, hold <= 6}, 32'h1);
        rdchk(a_status, 32'hF8, 32'h18);
        rdchk(a_cause, 32'h02, 32'h00);
        wr(a_cause, 32'h03);
        sleeping <= 1'b1;
        repeat (4) @(posedge clk_sys);
        fire(3);
        wait_hold(hold);
        rdchk(a_status, 32'h18, 32'h10);
        rdchk(a_cause, 32'hFF, 32'h03);
        fire(2);
        wait_hold(hold);
        rdchk(a_status, 32'h18, 32'h00);
        sleeping <= 1'b0;
    endtask

    task automatic t_brownout();
        wr(a_config, 32'h01);
        wr(a_cause, 32'h03);
        fire(1);
        wait_hold(hold);
        chk({31'h0, hold >= HOLD_MIN && hold <= HOLD_XTAL + SLACK}, 32'h1);
        rdchk(a_cause, 32'hFF, 32'h02);
        fire(1);
        repeat (10) @(posedge clk_sys);
        fire(1);
        wait_hold(hold);
        // without a restart the hold would end well before a full interval
        chk({31'h0, hold >= HOLD_MIN}, 32'h1);
        wr(a_config, 32'h0D);
        fire(1);
        wait_hold(hold);
        chk({31'h0, hold >= HOLD_RC && hold < HOLD_XTAL}, 32'h1);
        wr(a_config, 32'h00);
        @(posedge clk_sys);
        wake_event <= 1'b1;
        @(posedge clk_sys);
        wake_event <= 1'b0;
        wait_hold(hold);
        chk({31'h0, hold >= HOLD_MIN - HOLD_RC && hold <= HOLD_XTAL - HOLD_RC + SLACK}, 32'h1);
    endtask

    // ==============================================================
    // main sequence
    // ==============================================================
    initial
    begin
        num_errors      = 0;
        n_tests         = 0;
        cyc             = 0;
        arst_n          = 1'b0;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = 12'h000;
        pwdata          = 32'h0000_0000;
        poweron_event   = 1'b0;
        brownout_event  = 1'b0;
        watchdog_event  = 1'b0;
        ext_reset_pin_n = 1'b1;
        sleeping        = 1'b0;
        wake_event      = 1'b0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_poweron();
        t_cause_bits();
        t_pin_irq();
        t_watchdog_and_sleep();
        t_brownout();
        end_sim();
    end
endmodule // tb
